// File: logic/nso_pkg.sv
package nso_pkg;
	localparam int CUR_W = 16;
	localparam int TIME_W = 16;
	localparam int MAG_W = 32;
	// Currents in 0.01 A at 5 A rating, times in 0.01 s
	localparam logic [CUR_W-1:0] DT_PK_MIN = 16'h0032;
	localparam logic [CUR_W-1:0] DT_PK_MAX = 16'h05DC;
	localparam logic [CUR_W-1:0] LO_PK_DEF = 16'h0032;
	localparam logic [CUR_W-1:0] HI_PK_DEF = 16'h00FA;
	localparam logic [CUR_W-1:0] INV_PK_MIN = 16'h0032;
	localparam logic [CUR_W-1:0] INV_PK_MAX = 16'h03E8;
	localparam logic [CUR_W-1:0] INV_PK_DEF = 16'h01C2;
	localparam logic [TIME_W-1:0] DLY_MIN = 16'h0000;
	localparam logic [TIME_W-1:0] DLY_MAX = 16'h1770;
	localparam logic [TIME_W-1:0] LO_DLY_DEF = 16'h0096;
	localparam logic [TIME_W-1:0] HI_DLY_DEF = 16'h0096;
	localparam logic [TIME_W-1:0] IEC_MUL_MIN = 16'h0005;
	localparam logic [TIME_W-1:0] IEC_MUL_MAX = 16'h0140;
	localparam logic [TIME_W-1:0] IEC_MUL_DEF = 16'h0032;
	localparam logic [TIME_W-1:0] ANSI_DIAL_MIN = 16'h0032;
	localparam logic [TIME_W-1:0] ANSI_DIAL_MAX = 16'h05DC;
	localparam logic [TIME_W-1:0] ANSI_DIAL_DEF = 16'h01F4;
	// Percentages of the inverse pickup and of nominal current, then phase multiple, nominal current and 1 A scale factor
	localparam logic [MAG_W-1:0] PCT_FULL = 32'h0000_0064;
	localparam logic [MAG_W-1:0] PCT_PICKUP = 32'h0000_006E;
	localparam logic [MAG_W-1:0] PCT_DROP = 32'h0000_005F;
	localparam logic [MAG_W-1:0] PCT_DISK = 32'h0000_005A;
	localparam logic [MAG_W-1:0] PCT_END = 32'h0000_0005;
	localparam logic [MAG_W-1:0] PCT_MIN_NEG = 32'h0000_000A;
	localparam logic [MAG_W-1:0] PHASE_MULT = 32'h0000_0004;
	localparam logic [MAG_W-1:0] NOM_5A = 32'h0000_01F4;
	localparam logic [MAG_W-1:0] RATED_DIV = 32'h0000_0005;
	localparam int CLK_HZ = 25_000_000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	typedef enum logic [1:0] {CFG_OFF, CFG_DT, CFG_ANSI, CFG_IEC} nso_cfg_t;
	typedef enum logic [1:0] {IEC_NORMAL, IEC_VERY, IEC_EXTREME} nso_iec_t;
	typedef enum logic [1:0] {ANSI_EXTREME, ANSI_INV, ANSI_MODERATE, ANSI_VERY} nso_ansi_t;
	typedef enum logic {RST_INSTANT, RST_DISK} nso_rst_t;
	typedef struct packed {
		logic protection_function_switch;
		nso_cfg_t cfg;
		nso_iec_t iec_curve;
		nso_ansi_t ansi_curve_select;
		nso_rst_t inverse_reset_select;
		logic [CUR_W-1:0] lo_pk;
		logic [TIME_W-1:0] lo_dly;
		logic [CUR_W-1:0] hi_pk;
		logic [TIME_W-1:0] hi_dly;
		logic [CUR_W-1:0] inverse_pickup_level;
		logic [TIME_W-1:0] iec_mult;
		logic [TIME_W-1:0] inverse_time_scale;
		logic scale_inf;
	} nso_set_t;
	localparam nso_set_t SET_DEF = '{1'b0, CFG_OFF, IEC_EXTREME, ANSI_EXTREME,
		RST_INSTANT, LO_PK_DEF, LO_DLY_DEF, HI_PK_DEF, HI_DLY_DEF,
		INV_PK_DEF, IEC_MUL_DEF, ANSI_DIAL_DEF, 1'b0};
	typedef struct packed {
		logic [CUR_W-1:0] neg_seq;
		logic [CUR_W-1:0] phase_max;
	} nso_meas_t;
	typedef struct packed {
		logic lo_pu;
		logic lo_trip;
		logic hi_pu;
		logic hi_trip;
		logic inv_pu;
		logic inv_trip;
		logic disk_pu;
		logic trip;
		logic off;
		logic blocked;
		logic active;
	} nso_stat_t;
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction
endpackage

// File: logic/nso_dt_stage.sv
`timescale 1ns/1ps
`default_nettype none
module nso_dt_stage (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic enable_i,
	input wire logic tick_i,
	input wire logic [31:0] level_i,
	input wire logic [15:0] pickup_i,
	input wire logic [15:0] delay_i,
	output logic pickup_o,
	output logic trip_o
);
	typedef struct packed {
		logic pu;
		logic trip;
		logic [15:0] cnt;
	} nso_dt_st_t;
	nso_dt_st_t st;
	nso_dt_st_t next_st;
	always_comb begin
		next_st = st;
		if (!enable_i || level_i < 32'(pickup_i)) begin
			next_st = '0;
		end else begin
			next_st.pu = 1'b1;
			if (st.cnt >= delay_i) begin
				next_st.trip = 1'b1;
			end else if (tick_i && st.pu) begin
				next_st.cnt = st.cnt + 16'h0001;
			end
		end
	end
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign pickup_o = st.pu;
	assign trip_o = st.trip;
endmodule
`default_nettype wire

// File: logic/nso_inv_acc.sv
`timescale 1ns/1ps
`default_nettype none
module nso_inv_acc (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic clear_i,
	input wire logic advance_i,
	input wire logic unwind_i,
	input wire logic never_trip_i,
	input wire logic [15:0] fwd_rate_i,
	input wire logic [15:0] rev_rate_i,
	input wire logic [31:0] limit_i,
	output logic [31:0] acc_o,
	output logic trip_o
);
	typedef struct packed {
		logic [31:0] acc;
		logic trip;
	} nso_acc_st_t;
	nso_acc_st_t st;
	nso_acc_st_t next_st;
	always_comb begin
		next_st = st;
		if (clear_i) begin
			next_st = '0;
		end else if (advance_i) begin
			next_st.acc = (st.acc >= limit_i) ? st.acc : st.acc + 32'(fwd_rate_i);
		end else if (unwind_i) begin
			next_st.acc = (st.acc > 32'(rev_rate_i)) ? st.acc - 32'(rev_rate_i) : '0;
		end
		if (!clear_i) begin
			// Trip stands until the stage drops out or is cleared
			next_st.trip = !never_trip_i && (st.trip || (advance_i && st.acc >= limit_i));
		end
	end
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign acc_o = st.acc;
	assign trip_o = st.trip;
endmodule
`default_nettype wire

// File: logic/nso_prot.sv
// What this block does
// (R1) Low stage picks up at its pickup and trips after its delay.
// (R2) High stage works alike with its own pickup and delay.
// (R3) Function switch, off after reset, stops every pickup and trip.
// (R4) Inverse stage picks up above 110 percent, drops at 95 percent.
// (R5) Inverse pickup spans 0.50 to 10.00 A, default 4.50 A.
// (R6) IEC curve choice of three, extremely inverse after reset.
// (R7) ANSI curve choice of four, extremely inverse after reset.
// (R8) IEC multiplier spans 0.05 to 3.20 s, default 0.50 s.
// (R9) ANSI dial spans 0.50 to 15.00 s, default 5.00 s.
// (R10) Infinite scale still picks up but never trips.
// (R11) ANSI reset is instantaneous or disk emulation.
// (R12) On a 1 A device the measured currents multiply by five.
// (R13) Configuration disabled, definite only, or definite plus inverse.
// (R14) Pass current only if at least 10 percent nominal and phases below 4x.
// (R15) Disk unwinds below 90, holds 90 to 95, resets below 5 percent.
// (R16) IEC stage drops at 95 percent and clears its delay at once.
// (R17) External block input disables the whole protection.
// (R18) Common trip is the OR of all stage trips; pickups separate.
// (R19) Compare per update, time on one clock, reset clears all state and loads the default settings.
`timescale 1ns/1ps
`default_nettype none
module nso_prot #(
	parameter int TICK_CYC = nso_pkg::TICK_CYC,
	parameter logic [31:0] TRIP_UNIT = 32'h0000_0064
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic block_i,
	input wire logic rated_1a_i,
	input wire logic set_load_i,
	input wire nso_pkg::nso_set_t set_i,
	input wire logic meas_valid_i,
	input wire nso_pkg::nso_meas_t meas_i,
	input wire logic [15:0] fwd_rate_i,
	input wire logic [15:0] rev_rate_i,
	output logic [1:0] curve_o,
	output logic disk_unwind_o,
	output nso_pkg::nso_stat_t stat_o
);
	localparam int TW = $clog2(TICK_CYC + 1);
	typedef struct packed {
		nso_pkg::nso_set_t set;
		logic blk_ff1;
		logic blk_ff2;
		logic [TW-1:0] tick_cnt;
		logic tick;
		logic [31:0] neg;
		logic [31:0] phs;
		logic inv_pu;
	} nso_st_t;
	nso_st_t st;
	nso_st_t next_st;
	logic [31:0] pick_mag;
	logic meas_ok;
	logic dt_en;
	logic inv_en;
	logic is_iec;
	logic disk_mode;
	logic above_pu;
	logic below_drop;
	logic below_disk;
	logic below_end;
	logic acc_clear;
	logic acc_adv;
	logic acc_unwind;
	logic [31:0] limit;
	logic [31:0] acc;
	logic lo_pu;
	logic lo_trip;
	logic hi_pu;
	logic hi_trip;
	logic inv_trip;
	////////////////////////////////////////////////////////////////////////////////
	// Settings, measurement capture, block synchroniser, time base
	always_comb begin
		next_st = st;
		next_st.blk_ff1 = block_i;
		next_st.blk_ff2 = st.blk_ff1;
		next_st.tick = 1'b0;
		if (st.tick_cnt == TW'(TICK_CYC - 1)) begin
			next_st.tick_cnt = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.tick_cnt = st.tick_cnt + TW'(1);
		end
		if (set_load_i) begin
			next_st.set = set_i;
			next_st.set.lo_pk = nso_pkg::clamp(set_i.lo_pk, nso_pkg::DT_PK_MIN,
				nso_pkg::DT_PK_MAX); // R1
			next_st.set.lo_dly = nso_pkg::clamp(set_i.lo_dly, nso_pkg::DLY_MIN,
				nso_pkg::DLY_MAX); // R1
			next_st.set.hi_pk = nso_pkg::clamp(set_i.hi_pk, nso_pkg::DT_PK_MIN,
				nso_pkg::DT_PK_MAX); // R2
			next_st.set.hi_dly = nso_pkg::clamp(set_i.hi_dly, nso_pkg::DLY_MIN,
				nso_pkg::DLY_MAX); // R2
			next_st.set.inverse_pickup_level = nso_pkg::clamp(set_i.inverse_pickup_level,
				nso_pkg::INV_PK_MIN, nso_pkg::INV_PK_MAX); // R5
			next_st.set.iec_mult = nso_pkg::clamp(set_i.iec_mult, nso_pkg::IEC_MUL_MIN,
				nso_pkg::IEC_MUL_MAX); // R8
			next_st.set.inverse_time_scale = nso_pkg::clamp(set_i.inverse_time_scale,
				nso_pkg::ANSI_DIAL_MIN, nso_pkg::ANSI_DIAL_MAX); // R9
			if (set_i.iec_curve > nso_pkg::IEC_EXTREME) begin
				next_st.set.iec_curve = nso_pkg::IEC_EXTREME; // R6
			end
		end
		if (meas_valid_i) begin
			// Scale a 1 A device onto the 5 A setting grid
			if (rated_1a_i) begin
				next_st.neg = 32'(meas_i.neg_seq) * nso_pkg::RATED_DIV; // R12
				next_st.phs = 32'(meas_i.phase_max) * nso_pkg::RATED_DIV; // R12
			end else begin
				next_st.neg = 32'(meas_i.neg_seq);
				next_st.phs = 32'(meas_i.phase_max);
			end
		end
		if (!inv_en) begin
			next_st.inv_pu = 1'b0;
		end else if (above_pu) begin
			next_st.inv_pu = 1'b1; // R4
		end else if (below_drop) begin
			next_st.inv_pu = 1'b0; // R4 R16
		end
	end
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			st <= '0;
			st.set <= nso_pkg::SET_DEF; // R19 R3 R6 R7
		end else begin
			st <= next_st;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Release conditions and inverse-stage thresholds
	always_comb begin
		meas_ok = st.neg * nso_pkg::PCT_FULL >= nso_pkg::NOM_5A * nso_pkg::PCT_MIN_NEG
			&& st.phs < nso_pkg::NOM_5A * nso_pkg::PHASE_MULT; // R14
		dt_en = st.set.protection_function_switch && !st.blk_ff2 // R3 R17
			&& st.set.cfg != nso_pkg::CFG_OFF && meas_ok; // R13 R14
		is_iec = st.set.cfg == nso_pkg::CFG_IEC;
		inv_en = dt_en && (is_iec || st.set.cfg == nso_pkg::CFG_ANSI); // R13
		disk_mode = st.set.cfg == nso_pkg::CFG_ANSI
			&& st.set.inverse_reset_select == nso_pkg::RST_DISK; // R11
		pick_mag = 32'(st.set.inverse_pickup_level);
		above_pu = st.neg * nso_pkg::PCT_FULL > pick_mag * nso_pkg::PCT_PICKUP; // R4
		below_drop = st.neg * nso_pkg::PCT_FULL <= pick_mag * nso_pkg::PCT_DROP; // R4
		below_disk = st.neg * nso_pkg::PCT_FULL < pick_mag * nso_pkg::PCT_DISK; // R15
		below_end = st.neg * nso_pkg::PCT_FULL < pick_mag * nso_pkg::PCT_END; // R15
		if (is_iec) begin
			limit = 32'(st.set.iec_mult) * TRIP_UNIT; // R8
			curve_o = st.set.iec_curve; // R6
		end else begin
			limit = 32'(st.set.inverse_time_scale) * TRIP_UNIT; // R9
			curve_o = st.set.ansi_curve_select; // R7
		end
		acc_clear = !inv_en || (!disk_mode && !st.inv_pu) // R16 R11
			|| (disk_mode && below_end); // R15
		acc_adv = st.inv_pu && st.tick;
		acc_unwind = disk_mode && below_disk && !st.inv_pu && st.tick; // R15
		disk_unwind_o = acc_unwind;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Stages
	nso_dt_stage u_lo (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.enable_i(dt_en),
		.tick_i(st.tick),
		.level_i(st.neg),
		.pickup_i(st.set.lo_pk),
		.delay_i(st.set.lo_dly),
		.pickup_o(lo_pu),
		.trip_o(lo_trip)
	); // R1
	nso_dt_stage u_hi (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.enable_i(dt_en),
		.tick_i(st.tick),
		.level_i(st.neg),
		.pickup_i(st.set.hi_pk),
		.delay_i(st.set.hi_dly),
		.pickup_o(hi_pu),
		.trip_o(hi_trip)
	); // R2
	nso_inv_acc u_inv (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.clear_i(acc_clear),
		.advance_i(acc_adv),
		.unwind_i(acc_unwind),
		.never_trip_i(st.set.scale_inf || !st.inv_pu),
		.fwd_rate_i(fwd_rate_i),
		.rev_rate_i(rev_rate_i),
		.limit_i(limit),
		.acc_o(acc),
		.trip_o(inv_trip)
	); // R10
	always_comb begin
		stat_o.lo_pu = lo_pu;
		stat_o.lo_trip = lo_trip;
		stat_o.hi_pu = hi_pu;
		stat_o.hi_trip = hi_trip;
		stat_o.inv_pu = st.inv_pu;
		stat_o.inv_trip = inv_trip;
		stat_o.disk_pu = disk_mode && !st.inv_pu && acc != '0;
		stat_o.trip = lo_trip || hi_trip || inv_trip; // R18
		stat_o.off = !st.set.protection_function_switch;
		stat_o.blocked = st.blk_ff2;
		stat_o.active = st.set.protection_function_switch && !st.blk_ff2
			&& st.set.cfg != nso_pkg::CFG_OFF;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);
	a_lo_trip_pu: assert property (lo_trip |-> lo_pu && $past(dt_en)) // R1
		else $error("low stage tripped without pickup");
	a_hi_trip_pu: assert property (hi_trip |-> hi_pu) // R2
		else $error("high stage tripped without pickup");
	a_switch_off_quiet: assert property (!st.set.protection_function_switch ##1
		!st.set.protection_function_switch |-> !lo_pu && !hi_pu && !stat_o.trip) // R3
		else $error("pickup while switched off");
	a_inv_pickup: assert property (inv_en && above_pu |=> st.inv_pu) // R4
		else $error("inverse stage missed pickup");
	a_inv_never_trip: assert property (st.set.scale_inf [*2] |-> !inv_trip) // R10
		else $error("inverse trip with infinite scale");
	a_dt_only_absent: assert property (st.set.cfg == nso_pkg::CFG_DT |=>
		!st.inv_pu && acc == '0) // R13
		else $error("inverse stage live in definite-only mode");
	a_gate_reset: assert property (!meas_ok |=> !lo_pu && !hi_pu && acc == '0) // R14
		else $error("timers kept while current out of range");
	a_disk_hold: assert property (disk_mode && inv_en && !st.inv_pu && !below_disk
		&& below_drop |=> $stable(acc)) // R15
		else $error("disk moved inside hold band");
	a_iec_clear: assert property (inv_en && is_iec && below_drop |=> ##1 acc == '0) // R16
		else $error("IEC delay not cleared at dropout");
	a_block_quiet: assert property (st.blk_ff2 |=> !lo_pu && !hi_pu && !st.inv_pu) // R17
		else $error("pickup while blocked");
	a_reset_clear: assert property (@(posedge mclk_i) disable iff (1'b0)
		reset_i |=> !stat_o.trip && st.set == nso_pkg::SET_DEF) // R19
		else $error("reset left trip or settings");
	// Setting store ranges
	a_curve_range: assert property (st.set.iec_curve <= nso_pkg::IEC_EXTREME) // R6
		else $error("IEC curve code out of range");
	a_dt_pk_range: assert property (st.set.lo_pk >= nso_pkg::DT_PK_MIN // R1 R2
		&& st.set.lo_pk <= nso_pkg::DT_PK_MAX && st.set.hi_pk >= nso_pkg::DT_PK_MIN
		&& st.set.hi_pk <= nso_pkg::DT_PK_MAX)
		else $error("definite pickup out of range");
	a_dly_range: assert property (st.set.lo_dly <= nso_pkg::DLY_MAX // R1 R2
		&& st.set.hi_dly <= nso_pkg::DLY_MAX)
		else $error("definite delay out of range");
	a_inv_pk_range: assert property (st.set.inverse_pickup_level >= nso_pkg::INV_PK_MIN // R5
		&& st.set.inverse_pickup_level <= nso_pkg::INV_PK_MAX)
		else $error("inverse pickup out of range");
	a_mul_range: assert property (st.set.iec_mult >= nso_pkg::IEC_MUL_MIN // R8
		&& st.set.iec_mult <= nso_pkg::IEC_MUL_MAX)
		else $error("IEC multiplier out of range");
	a_dial_range: assert property (st.set.inverse_time_scale >= nso_pkg::ANSI_DIAL_MIN // R9
		&& st.set.inverse_time_scale <= nso_pkg::ANSI_DIAL_MAX)
		else $error("ANSI dial out of range");
	// Stage behaviour
	a_lo_pickup: assert property (dt_en && st.neg >= 32'(st.set.lo_pk) |=> lo_pu) // R1
		else $error("low stage missed pickup");
	a_lo_below: assert property (st.neg < 32'(st.set.lo_pk) |=> !lo_pu) // R1
		else $error("low stage picked up below setting");
	a_hi_pickup: assert property (dt_en && st.neg >= 32'(st.set.hi_pk) |=> hi_pu) // R2
		else $error("high stage missed pickup");
	a_hi_below: assert property (st.neg < 32'(st.set.hi_pk) |=> !hi_pu) // R2
		else $error("high stage picked up below setting");
	a_inv_drop: assert property (st.inv_pu && below_drop |=> !st.inv_pu) // R4 R16
		else $error("inverse stage missed dropout");
	a_inv_trip_pu: assert property (inv_trip |-> $past(st.inv_pu)) // R4
		else $error("inverse trip without pickup");
	a_inf_pickup: assert property (inv_en && above_pu && st.set.scale_inf // R10
		|=> st.inv_pu && !inv_trip)
		else $error("infinite scale blocked pickup or tripped");
	a_adv_step: assert property (acc_adv && !acc_clear && acc < limit // R8 R9
		|=> acc == $past(acc) + 32'($past(fwd_rate_i)))
		else $error("inverse delay advanced by wrong step");
	a_unwind_step: assert property (acc_unwind && !acc_clear && acc > 32'(rev_rate_i) // R15
		|=> acc == $past(acc) - 32'($past(rev_rate_i)))
		else $error("disk unwound by wrong step");
	a_disk_end: assert property (disk_mode && inv_en && below_end |=> acc == '0) // R15
		else $error("disk emulation kept below end level");
	a_ansi_clear: assert property (inv_en && !disk_mode && !st.inv_pu |=> acc == '0) // R11
		else $error("instant reset kept inverse delay");
	a_active_gate: assert property (!stat_o.active // R3 R17
		|=> !lo_pu && !hi_pu && !st.inv_pu)
		else $error("pickup while not active");
	a_cfg_off: assert property (st.set.cfg == nso_pkg::CFG_OFF |=> !lo_pu && !hi_pu) // R13
		else $error("definite stage live while disabled");
	a_meas_hold: assert property (!meas_valid_i |=> $stable(st.neg)) // R19
		else $error("measurement changed without strobe");
	a_rated_scale: assert property (meas_valid_i && rated_1a_i // R12
		|=> st.neg == 32'($past(meas_i.neg_seq)) * nso_pkg::RATED_DIV)
		else $error("1 A measurement not scaled");
	c_hi_trip: cover property (hi_pu ##1 hi_trip);
	c_lo_trip: cover property (lo_pu ##1 lo_trip);
	c_inv_trip: cover property (st.inv_pu ##1 inv_trip);
	c_disk_unwind: cover property (acc_unwind ##1 stat_o.disk_pu);
	c_block_drop: cover property (lo_pu ##1 st.blk_ff2);
endmodule
`default_nettype wire

// File: verification/nso_meas_model.sv
`timescale 1ns/1ps
`default_nettype none
module nso_meas_model (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [15:0] neg_i,
	input wire logic [15:0] phase_i,
	input wire logic [15:0] rate_i,
	input wire logic blk_i,
	output logic meas_valid_o,
	output nso_pkg::nso_meas_t meas_o,
	output logic [15:0] fwd_rate_o,
	output logic [15:0] rev_rate_o,
	output logic block_o
);
	logic [1:0] cnt;
	// One filtered sample every four clocks
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cnt <= 2'h0;
		end else begin
			cnt <= cnt + 2'h1;
		end
	end
	assign meas_valid_o = (cnt == 2'h3) && !reset_i;
	// Outside the strobe the sample bus carries garbage
	assign meas_o = meas_valid_o ? {neg_i, phase_i} : {~neg_i, ~phase_i};
	assign fwd_rate_o = rate_i;
	assign rev_rate_o = rate_i;
	assign block_o = blk_i;
endmodule
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int TK = 10;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic rated_1a_i = 1'b0;
	logic set_load_i = 1'b0;
	logic blk = 1'b0;
	logic block_i;
	logic meas_valid_i;
	logic [15:0] neg = 16'h0000;
	logic [15:0] ph = 16'h0064;
	logic [15:0] rate = 16'h0001;
	logic [15:0] fwd_rate_i;
	logic [15:0] rev_rate_i;
	logic [1:0] curve_o;
	logic disk_unwind_o;
	nso_pkg::nso_set_t set_i = nso_pkg::SET_DEF;
	nso_pkg::nso_meas_t meas_i;
	nso_pkg::nso_stat_t st;
	int bad_count = 0;
	int n_tests = 0;
	int seed = 48;
	int unw = 0;
	int u0 = 0;
	int d;
	int i;

	nso_meas_model u_src (.mclk_i(mclk_i), .reset_i(reset_i), .neg_i(neg), .phase_i(ph),
		.rate_i(rate), .blk_i(blk), .meas_valid_o(meas_valid_i), .meas_o(meas_i),
		.fwd_rate_o(fwd_rate_i), .rev_rate_o(rev_rate_i), .block_o(block_i));
	nso_prot #(.TICK_CYC(TK), .TRIP_UNIT(32'h0000_0001)) u_dut (.mclk_i(mclk_i),
		.reset_i(reset_i), .block_i(block_i), .rated_1a_i(rated_1a_i),
		.set_load_i(set_load_i), .set_i(set_i), .meas_valid_i(meas_valid_i),
		.meas_i(meas_i), .fwd_rate_i(fwd_rate_i), .rev_rate_i(rev_rate_i),
		.curve_o(curve_o), .disk_unwind_o(disk_unwind_o), .stat_o(st));

	initial begin
		forever #20 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		if (disk_unwind_o === 1'b1) unw <= unw + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("Checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic load(input nso_pkg::nso_set_t s);
		set_i = s;
		set_load_i = 1'b1;
		cyc(1);
		set_load_i = 1'b0;
		cyc(1);
	endtask
	task automatic drive(input logic [15:0] n, input logic [15:0] p);
		neg = n;
		ph = p;
		cyc(10);
	endtask
	// Bounded wait for the common trip
	task automatic wait_trip(input int bound);
		n_tests++;
		for (i = 0; i < bound && st.trip !== 1'b1; i++) cyc(1);
		if (st.trip !== 1'b1) begin
			bad_count++;
			$display("[FAIL] trip expected 1 seen %b", st.trip);
			end_sim();
		end
	endtask
	function automatic nso_pkg::nso_set_t base(input nso_pkg::nso_cfg_t c);
		base = nso_pkg::SET_DEF;
		base.protection_function_switch = 1'b1;
		base.cfg = c;
		base.lo_pk = 16'h05DC;
		base.hi_pk = 16'h05DC;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		nso_pkg::nso_set_t s;
		cyc(20);
		reset_i = 1'b0;
		cyc(1);
		chk("off", 16'h0002, {st.off, st.active});
		drive(16'h03E8, 16'h0064);
		chk("switched off", 16'h0000, {st.lo_pu, st.hi_pu, st.inv_pu, st.trip});
		drive(16'h0000, 16'h0064);
		// Every curve code, the unused IEC code falls back to extreme
		s = base(nso_pkg::CFG_IEC);
		for (d = 0; d < 4; d++) begin
			s.iec_curve = nso_pkg::nso_iec_t'(d);
			load(s);
			chk("iec curve", (d == 3) ? 16'h0002 : 16'(d), curve_o);
		end
		s = base(nso_pkg::CFG_ANSI);
		for (d = 0; d < 4; d++) begin
			s.ansi_curve_select = nso_pkg::nso_ansi_t'(d);
			load(s);
			chk("ansi curve", 16'(d), curve_o);
		end
		// Inverse pickup clamps to 10.00 A: 110 up, 95 down
		s = base(nso_pkg::CFG_IEC);
		s.inverse_pickup_level = 16'hFFFF;
		s.iec_mult = 16'h0000;
		load(s);
		drive(16'h044C, 16'h05DC);
		chk("inv at 110", 16'h0000, st.inv_pu);
		drive(16'h044D, 16'h05DC);
		chk("inv above 110", 16'h0001, st.inv_pu);
		drive(16'h03B7, 16'h05DC);
		chk("inv hold", 16'h0001, st.inv_pu);
		chk("inv early", 16'h0000, st.inv_trip);
		wait_trip(8 * TK);
		drive(16'h03B6, 16'h05DC);
		chk("inv drop", 16'h0000, st.inv_pu);
		drive(16'h044D, 16'h05DC);
		chk("inv restart", 16'h0000, st.inv_trip);
		drive(16'h0000, 16'h0064);
		s.scale_inf = 1'b1;
		load(s);
		drive(16'h044D, 16'h05DC);
		cyc(12 * TK);
		chk("inf", 16'h0002, {st.inv_pu, st.trip});
		// Definite stages, random delays
		drive(16'h0000, 16'h0064);
		d = 2 + ($unsigned($random(seed)) % 5);
		s = base(nso_pkg::CFG_DT);
		s.lo_pk = 16'h0064;
		s.lo_dly = 16'(d);
		load(s);
		drive(16'h0063, 16'h0064);
		chk("lo below", 16'h0000, st.lo_pu);
		drive(16'h0064, 16'h0064);
		chk("lo at", 16'h0003, {st.active, st.lo_pu});
		cyc((d - 1) * TK - 10);
		chk("lo early", 16'h0000, st.lo_trip);
		wait_trip(4 * TK);
		blk = 1'b1;
		cyc(6);
		chk("blocked", 16'h0008, {st.blocked, st.active, st.lo_pu, st.trip});
		blk = 1'b0;
		drive(16'h0000, 16'h0064);
		d = 2 + ($unsigned($random(seed)) % 5);
		s.lo_dly = 16'h1770;
		s.hi_pk = 16'h012C;
		s.hi_dly = 16'(d);
		load(s);
		drive(16'h012B, 16'h0064);
		chk("hi below", 16'h0001, {st.hi_pu, st.lo_pu});
		drive(16'h0258, 16'h0064);
		chk("hi at, no inverse", 16'h0003, {st.inv_pu, st.hi_pu, st.lo_pu});
		cyc((d - 1) * TK - 10);
		chk("hi early", 16'h0000, st.hi_trip);
		wait_trip(4 * TK);
		chk("lo held", 16'h0000, st.lo_trip);
		drive(16'h0258, 16'h07D0);
		chk("phase limit", 16'h0000, {st.lo_pu, st.hi_pu, st.trip});
		drive(16'h0258, 16'h0064);
		drive(16'h0031, 16'h0064);
		chk("low neg", 16'h0000, {st.lo_pu, st.trip});
		rated_1a_i = 1'b1;
		drive(16'h0013, 16'h0014);
		chk("1a below", 16'h0000, st.lo_pu);
		drive(16'h0014, 16'h0014);
		chk("1a at", 16'h0001, st.lo_pu);
		rated_1a_i = 1'b0;
		drive(16'h0000, 16'h0064);
		s.cfg = nso_pkg::CFG_OFF;
		load(s);
		drive(16'h0258, 16'h0064);
		chk("cfg off", 16'h0000, {st.lo_pu, st.hi_pu, st.inv_pu});
		// Disk emulation: hold between 90 and 95, unwind below 90
		drive(16'h0000, 16'h0064);
		s = base(nso_pkg::CFG_ANSI);
		s.inverse_reset_select = nso_pkg::RST_DISK;
		s.inverse_pickup_level = 16'h00C8;
		s.inverse_time_scale = 16'hFFFF;
		rate = 16'h0004;
		load(s);
		drive(16'h012C, 16'h0064);
		cyc(4 * TK);
		u0 = unw;
		drive(16'h00B9, 16'h0064);
		cyc(4 * TK);
		chk("disk hold", 16'h0000, 16'(unw - u0));
		chk("disk pu", 16'h0001, st.disk_pu);
		drive(16'h00AA, 16'h0064);
		cyc(4 * TK);
		chk("disk unwind", 16'h0001, 16'(unw != u0));
		end_sim();
	end
endmodule
`default_nettype wire
